// File: hdl/tccs_consts.svh
/*
  Constants of the timer count-clock selector: register byte offsets,
  field positions, reset values and prescaler tap positions.
  Assumes inclusion by bare name from files that need these values.
*/
`ifndef TCCS_CONSTS_SVH
`define TCCS_CONSTS_SVH

// Register byte offsets
`define TCCS_OFF_CH2     8'h00
`define TCCS_OFF_CH3     8'h04
`define TCCS_OFF_CH4     8'h08
`define TCCS_OFF_CH5     8'h0C
`define TCCS_OFF_STATUS  8'h10

// Control register field positions
`define TCCS_PRIM_LSB    0
`define TCCS_EXT_LSB     3
`define TCCS_PHASE_BIT   6
`define TCCS_EDGE_LSB    6

// Control register reset value
`define TCCS_CTL_RESET   8'h00

// Prescaler width and tap shifts (divide by 2**shift)
`define TCCS_PRE_WIDTH   10
`define TCCS_SH_D2       1
`define TCCS_SH_D4       2
`define TCCS_SH_D8       3
`define TCCS_SH_D16      4
`define TCCS_SH_D32      5
`define TCCS_SH_D64      6
`define TCCS_SH_D256     8
`define TCCS_SH_D1024    10

`endif

// File: hdl/tccs_pkg.sv
/*
  Types of the timer count-clock selector.
  Assumes nothing of its surroundings.
*/
package tccs_pkg;

  // Count clock source chosen by the select fields
  typedef enum logic [3:0] {
    TCCS_SRC_D1    = 4'h0,
    TCCS_SRC_D2    = 4'h1,
    TCCS_SRC_D4    = 4'h2,
    TCCS_SRC_D8    = 4'h3,
    TCCS_SRC_D16   = 4'h4,
    TCCS_SRC_D32   = 4'h5,
    TCCS_SRC_D64   = 4'h6,
    TCCS_SRC_D256  = 4'h7,
    TCCS_SRC_D1024 = 4'h8,
    TCCS_SRC_PINA  = 4'h9,
    TCCS_SRC_PINB  = 4'hA,
    TCCS_SRC_PINC  = 4'hB,
    TCCS_SRC_PIN1A = 4'hC,
    TCCS_SRC_NONE  = 4'hF
  } tccs_src_t;

endpackage

// File: hdl/tccs_pin_edge.sv
/*
  Two-flop synchroniser and edge detector for a group of pins.
  Assumes pins are asynchronous to sys_clk; pinRise and pinFall are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module tccs_pin_edge #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Pins
  input  wire logic [WIDTH-1:0] pinIn,
  // Synchronised level and edges
  output logic      [WIDTH-1:0] pinLevel,
  output logic      [WIDTH-1:0] pinRise,
  output logic      [WIDTH-1:0] pinFall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  // Refuse a pin group that the logic cannot serve
  if (WIDTH < 1) $error("tccs_pin_edge: WIDTH must be at least 1");

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= pinIn;
      sync <= meta;
      prev <= sync;
    end
  end

  assign pinLevel = sync;
  assign pinRise  = sync & ~prev;
  assign pinFall  = ~sync & prev;

endmodule

`default_nettype wire

// File: hdl/tccs_top.sv
/*
  Count-clock selector for timer channels two to five with APB registers.
  Assumes an APB master on sys_clk and external count pins that are
  asynchronous; count enables go to channel counters on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tccs_consts.svh"

// Summary of operation
// RULE1 - With extended select zero, primary codes 0 to 3 count on the clock divided by 1, 4, 16 and 64.
// RULE2 - Extended codes 1, 2 and 3 count on the clock divided by 2, 8 and 32 whatever the primary code.
// RULE3 - On channel two, primary codes 4, 5 and 6 count on edges of external pins A, B and C.
// RULE4 - On channel two, primary code 7 counts on the clock divided by 1024.
// RULE5 - On channel two, extended code 4 divides by 256 and codes 5 to 7 are prohibited.
// RULE6 - On channels three and four, primary 4 to 7 give divide by 256, 1024, pin A and pin B, and extended 4 to 7 are prohibited.
// RULE7 - Channel five has a two-bit primary code; extended 4 divides by 256, 5 by 1024, 6 is prohibited and 7 counts the channel-one A pin.
// RULE8 - In phase counting mode channel two ignores the selection and counts from the phase inputs.
// RULE9 - Software changes the extended select only while the channel counter is stopped.
// RULE10 - On channel five an edge field picks rising, falling or both edges of the channel-one A pin.
// RULE11 - Divided clocks are one-cycle enables from one free-running prescaler, and pins are synchronised and edge-detected.
module tccs_top
  import tccs_pkg::*;
#(
  parameter int PRE_W = `TCCS_PRE_WIDTH
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External count pins
  input  wire logic        extCountPinA,
  input  wire logic        extCountPinB,
  input  wire logic        extCountPinC,
  input  wire logic        chan1IoPinA,
  // Count enables to channels two to five, and channel two direction
  output logic      [3:0]  countEn,
  output logic             chan2CountUp
);

  logic [7:0]       ctl2, ctl3, ctl4, ctl5;
  logic [PRE_W-1:0] pre;
  logic [3:0]       pinLevel, pinRise, pinFall;
  logic [3:0]       prohib;
  logic [3:0]       next_countEn;
  logic             pin1aEv, phaseEv;
  tccs_src_t        src2, src3, src4, src5;
  logic             apbAccess;
  logic             wrEn;

  // The widest tap needs the full prescaler width
  if (PRE_W < `TCCS_SH_D1024) $error("tccs_top: PRE_W too small");

  // Pins: 0 = A, 1 = B, 2 = C, 3 = channel-one A
  tccs_pin_edge #(.WIDTH(4)) uPins (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .pinIn    ({chan1IoPinA, extCountPinC, extCountPinB, extCountPinA}),
    .pinLevel (pinLevel),
    .pinRise  (pinRise),
    .pinFall  (pinFall)
  ); // RULE11

  // Free-running prescaler
  always_ff @(posedge sys_clk) begin
    if (!nrst) pre <= '0;
    else pre <= pre + 1'b1; // RULE11
  end

  // Tap fires once every 2**sh cycles
  function automatic logic tap(input logic [PRE_W-1:0] p, input int sh);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < sh; i++) begin
      if (!p[i]) ok = 1'b0;
    end
    return ok;
  endfunction

  function automatic logic srcEn(input tccs_src_t s,
                                 input logic [PRE_W-1:0] p,
                                 input logic [3:0] ev);
    logic e;
    case (s)
      TCCS_SRC_D1:    e = 1'b1;
      TCCS_SRC_D2:    e = tap(p, `TCCS_SH_D2);
      TCCS_SRC_D4:    e = tap(p, `TCCS_SH_D4);
      TCCS_SRC_D8:    e = tap(p, `TCCS_SH_D8);
      TCCS_SRC_D16:   e = tap(p, `TCCS_SH_D16);
      TCCS_SRC_D32:   e = tap(p, `TCCS_SH_D32);
      TCCS_SRC_D64:   e = tap(p, `TCCS_SH_D64);
      TCCS_SRC_D256:  e = tap(p, `TCCS_SH_D256);
      TCCS_SRC_D1024: e = tap(p, `TCCS_SH_D1024);
      TCCS_SRC_PINA:  e = ev[0];
      TCCS_SRC_PINB:  e = ev[1];
      TCCS_SRC_PINC:  e = ev[2];
      TCCS_SRC_PIN1A: e = ev[3];
      default:        e = 1'b0;
    endcase
    return e;
  endfunction

  // Decode of the select fields per channel kind (0 = ch2, 1 = ch3/4, 2 = ch5)
  function automatic tccs_src_t decode(input logic [1:0] kind,
                                       input logic [7:0] c);
    logic [2:0] pr;
    logic [2:0] ex;
    tccs_src_t  s;
    pr = c[`TCCS_PRIM_LSB +: 3];
    ex = c[`TCCS_EXT_LSB +: 3];
    if (kind == 2'd2) pr[2] = 1'b0;
    s = TCCS_SRC_NONE;
    case (ex)
      3'h0: begin
        case (pr)
          3'h0: s = TCCS_SRC_D1; // RULE1
          3'h1: s = TCCS_SRC_D4; // RULE1
          3'h2: s = TCCS_SRC_D16; // RULE1
          3'h3: s = TCCS_SRC_D64; // RULE1
          3'h4: s = (kind == 2'd0) ? TCCS_SRC_PINA : TCCS_SRC_D256; // RULE3 RULE6
          3'h5: s = (kind == 2'd0) ? TCCS_SRC_PINB : TCCS_SRC_D1024; // RULE3 RULE6
          3'h6: s = (kind == 2'd0) ? TCCS_SRC_PINC : TCCS_SRC_PINA; // RULE3 RULE6
          default: s = (kind == 2'd0) ? TCCS_SRC_D1024 : TCCS_SRC_PINB; // RULE4 RULE6
        endcase
      end
      3'h1: s = TCCS_SRC_D2; // RULE2
      3'h2: s = TCCS_SRC_D8; // RULE2
      3'h3: s = TCCS_SRC_D32; // RULE2
      3'h4: s = (kind == 2'd1) ? TCCS_SRC_NONE : TCCS_SRC_D256; // RULE5 RULE6 RULE7
      3'h5: s = (kind == 2'd2) ? TCCS_SRC_D1024 : TCCS_SRC_NONE; // RULE5 RULE7
      3'h6: s = TCCS_SRC_NONE; // RULE5 RULE6 RULE7
      default: s = (kind == 2'd2) ? TCCS_SRC_PIN1A : TCCS_SRC_NONE; // RULE7
    endcase
    return s;
  endfunction

  // Channel five edge choice on the channel-one A pin
  always_comb begin
    case (ctl5[`TCCS_EDGE_LSB +: 2])
      2'b00:   pin1aEv = pinRise[3]; // RULE10
      2'b01:   pin1aEv = pinFall[3]; // RULE10
      default: pin1aEv = pinRise[3] | pinFall[3]; // RULE10
    endcase
  end

  assign phaseEv = pinRise[0] | pinFall[0] | pinRise[1] | pinFall[1];
  assign src2 = decode(2'd0, ctl2);
  assign src3 = decode(2'd1, ctl3);
  assign src4 = decode(2'd1, ctl4);
  assign src5 = decode(2'd2, ctl5);

  always_comb begin
    next_countEn[0] = ctl2[`TCCS_PHASE_BIT] ? phaseEv
                    : srcEn(src2, pre, {1'b0, pinRise[2:0]}); // RULE8
    next_countEn[1] = srcEn(src3, pre, {1'b0, pinRise[2:0]});
    next_countEn[2] = srcEn(src4, pre, {1'b0, pinRise[2:0]});
    next_countEn[3] = srcEn(src5, pre, {pin1aEv, 3'b000});
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      countEn      <= 4'h0;
      chan2CountUp <= 1'b1;
      prohib       <= 4'h0;
    end else begin
      countEn <= next_countEn; // RULE11
      prohib  <= {src5 == TCCS_SRC_NONE, src4 == TCCS_SRC_NONE,
                  src3 == TCCS_SRC_NONE,
                  (src2 == TCCS_SRC_NONE) && !ctl2[`TCCS_PHASE_BIT]};
      if (ctl2[`TCCS_PHASE_BIT] && phaseEv)
        chan2CountUp <= pinLevel[0] ^ ~pinLevel[1]; // RULE8
    end
  end

  // APB slave: one wait state, answer in the second access cycle
  assign apbAccess = psel && penable && !pready;
  assign wrEn      = psel && penable && pready && pwrite;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apbAccess;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apbAccess) begin
        if (paddr == `TCCS_OFF_CH2) prdata <= {24'h000000, ctl2};
        else if (paddr == `TCCS_OFF_CH3) prdata <= {24'h000000, ctl3};
        else if (paddr == `TCCS_OFF_CH4) prdata <= {24'h000000, ctl4};
        else if (paddr == `TCCS_OFF_CH5) prdata <= {24'h000000, ctl5};
        else if (paddr == `TCCS_OFF_STATUS)
          prdata <= {24'h000000, countEn, prohib};
        else pslverr <= 1'b1;
      end
    end
  end

  // Extended select is expected to change only while counting is stopped
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctl2 <= `TCCS_CTL_RESET;
      ctl3 <= `TCCS_CTL_RESET;
      ctl4 <= `TCCS_CTL_RESET;
      ctl5 <= `TCCS_CTL_RESET;
    end else if (wrEn) begin // RULE9
      if (paddr == `TCCS_OFF_CH2) ctl2 <= {1'b0, pwdata[6:0]};
      else if (paddr == `TCCS_OFF_CH3) ctl3 <= {2'b00, pwdata[5:0]};
      else if (paddr == `TCCS_OFF_CH4) ctl4 <= {2'b00, pwdata[5:0]};
      else if (paddr == `TCCS_OFF_CH5) ctl5 <= {pwdata[7:3], 1'b0, pwdata[1:0]};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_ch2_div_one: assert property (
    nrst && ctl2[6:0] == 7'h00 |=> countEn[0]) // RULE1
    else $error("channel two divide by 1 not counting every cycle");
  a_ch3_div_four: assert property (
    ctl3[5:0] == 6'h01 && $stable(ctl3)
      |=> countEn[1] == ($past(pre[1:0]) == 2'b11)) // RULE1
    else $error("channel three divide by 4 enable wrong");
  a_ext_div_two: assert property (
    ctl4[5:3] == 3'h1 |=> countEn[2] == $past(pre[0])) // RULE2
    else $error("channel four divide by 2 enable wrong");
  a_ch2_pin_a: assert property (
    ctl2[6:0] == 7'h04 |=> countEn[0] == $past(pinRise[0])) // RULE3
    else $error("channel two pin A edge not followed");
  a_ch2_div_1024: assert property (
    ctl2[6:0] == 7'h07 |=> countEn[0] == ($past(pre) == '1)) // RULE4
    else $error("channel two divide by 1024 enable wrong");
  a_ch2_bad_code: assert property (
    ctl2[6] == 1'b0 && ctl2[5:3] >= 3'h5 |=> !countEn[0] && prohib[0]) // RULE5
    else $error("channel two prohibited code counted");
  a_ch3_bad_code: assert property (
    ctl3[5:3] >= 3'h4 [*2] |=> !countEn[1] && prohib[1]) // RULE6
    else $error("channel three prohibited code counted");
  a_ch5_bad_code: assert property (
    ctl5[5:3] == 3'h6 |=> !countEn[3]) // RULE7
    else $error("channel five prohibited code counted");
  a_ch2_phase: assert property (
    ctl2[6] |=> countEn[0] == $past(phaseEv)) // RULE8
    else $error("phase mode not counting phase edges");
  a_ch5_fall_edge: assert property (
    ctl5[7:3] == 5'b01111 |=> countEn[3] == $past(pinFall[3])) // RULE10
    else $error("channel five falling edge not followed");
  a_presc_runs: assert property (
    $past(nrst) |-> pre == $past(pre) + 1'b1) // RULE11
    else $error("prescaler did not advance");

  c_ch2_pin_count: cover property (ctl2[6:0] == 7'h04 ##1 countEn[0]);
  c_ch5_both_edges: cover property (ctl5[7] && ctl5[5:3] == 3'h7 ##1 countEn[3]);
  c_phase_count: cover property (ctl2[6] ##1 countEn[0]);
  c_apb_error: cover property (pready && pslverr);

endmodule

`default_nettype wire

// File: testbench/tccs_pin_model.sv
/*
  External count pin model: square waves of different rates on each pin.
  Assumes the bench clock; run low freezes every pin at its level.
*/
`timescale 1ns/1ps
`default_nettype none
module tccs_pin_model (
  // Clock and hold
  input  wire logic sys_clk,
  input  wire logic run,
  // Pins
  output logic      pinA,
  output logic      pinB,
  output logic      pinC,
  output logic      pin1A
);
  logic [5:0] cnt = 6'h00;
  logic [5:0] cntB;
  always @(posedge sys_clk) if (run) cnt <= cnt + 6'h01;
  // Pin B offset so its edges never meet those of pin A
  assign cntB  = cnt + 6'h04;
  assign pinA  = cnt[3];
  assign pinB  = cntB[4];
  assign pinC  = cnt[5];
  assign pin1A = cnt[2];
endmodule
`default_nettype wire

// File: testbench/tccs_top_tb.sv
/*
  Self-checking bench of the count-clock selector: every select code of
  every channel, pulse counts over a fixed window, APB readback and flags.
  Assumes the pin model above on the count pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tccs_consts.svh"
module tccs_top_tb;
  logic        sys_clk = 1'b0;
  logic        nrst, psel, penable, pwrite, run;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, pinA, pinB, pinC, pin1A;
  logic [3:0]  countEn;
  logic        countUp;
  int          nMismatch = 0;
  int          checkCount = 0;
  int          cyc = 0;

  tccs_top tccs_top_i (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extCountPinA(pinA), .extCountPinB(pinB), .extCountPinC(pinC),
    .chan1IoPinA(pin1A), .countEn(countEn), .chan2CountUp(countUp));
  tccs_pin_model tccs_pin_model_i (.sys_clk(sys_clk), .run(run),
    .pinA(pinA), .pinB(pinB), .pinC(pinC), .pin1A(pin1A));

  always #2 sys_clk = ~sys_clk;

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      nMismatch++;
      wrapUp();
    end
  end

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected word at %0t: %h vs %h", $time, got, exp);
    end
  endtask

  task automatic chkCount(input int got, input int exp);
    checkCount++;
    if (got != exp) begin
      nMismatch++;
      $display("unexpected count at %0t: %h vs %h", $time, got, exp);
    end
  endtask

  // One APB transfer; psel stays high so a next setup may follow at once
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only pready seen high, or else the bench timeout, ends this wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    penable <= 1'b0;
  endtask

  // Pulses expected in 1024 cycles; zero marks a prohibited code
  function automatic int expPulses(int ch, logic [2:0] p, logic [2:0] e,
                                   logic [1:0] g, bit ph);
    if (ph) return 192;
    case (e)
      3'h1: return 512;
      3'h2: return 128;
      3'h3: return 32;
      3'h0: begin
        if (p < 4 || ch == 3) return 1024 >> (2 * p[1:0]);
        if (ch == 0) return p == 4 ? 64 : p == 5 ? 32 : p == 6 ? 16 : 1;
        return p == 4 ? 4 : p == 5 ? 1 : p == 6 ? 64 : 32;
      end
      default: ;
    endcase
    if (ch == 0) return e == 4 ? 4 : 0;
    if (ch == 3) return e == 4 ? 4 : e == 5 ? 1 : e == 6 ? 0 : g[1] ? 256 : 128;
    return 0;
  endfunction

  initial begin
    logic [31:0] r, wd;
    logic        e;
    logic [2:0]  p;
    logic [1:0]  g;
    bit          ph;
    int          x, n, kmax, nUp;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b1;
    x = $urandom(13);
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chkWord({31'h0, countUp}, 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b0, `TCCS_OFF_CH2 + 8'(4 * c), 32'h0, r, e);
      chkWord(r, 32'h0);
    end
    apb(1'b0, `TCCS_OFF_STATUS, 32'h0, r, e);
    chkWord(r, 32'h000000F0);
    apb(1'b1, 8'h14, $urandom, r, e);
    chkWord({31'h0, e}, 32'h1);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chkWord(r, 32'h0);
    chkWord({31'h0, e}, 32'h1);
    for (int c = 0; c < 4; c++) begin
      for (int ex = 0; ex < 8; ex++) begin
        kmax = ex != 0 ? (c == 3 && ex == 7 ? 2 : 0) :
               (c == 0 ? 8 : c == 3 ? 3 : 7);
        for (int k = 0; k <= kmax; k++) begin
          wd = $urandom;
          p = ex == 0 ? 3'(k) : 3'($urandom);
          g = (c == 3 && ex == 7) ? 2'(k) : 2'($urandom);
          ph = (c == 0 && k == 8);
          wd[7:0] = c == 3 ? {g, 3'(ex), p} : {1'b0, ph, 3'(ex), p};
          // Select changes while the previous code still drives the channel enable
          apb(1'b1, `TCCS_OFF_CH2 + 8'(4 * c), wd, r, e);
          apb(1'b0, `TCCS_OFF_CH2 + 8'(4 * c), 32'h0, r, e);
          chkWord(r, wd & (c == 3 ? 32'hFB : 32'hFF));
          x = expPulses(c, p, 3'(ex), g, ph);
          apb(1'b0, `TCCS_OFF_STATUS, 32'h0, r, e);
          psel <= 1'b0;
          chkWord({31'h0, r[c]}, {31'h0, x == 0});
          repeat (16) @(posedge sys_clk);
          n = 0;
          nUp = 0;
          repeat (1024) begin
            @(posedge sys_clk);
            n += int'(countEn[c] === 1'b1);
            nUp += int'(countUp === 1'b1);
          end
          chkCount(n, x);
          // Pin pattern gives the up direction half of the time
          if (ph) chkCount(nUp, 512);
        end
      end
    end
    // Frozen pins must give no counts on channel two pin A
    apb(1'b1, `TCCS_OFF_CH2, 32'h04, r, e);
    psel <= 1'b0;
    run <= 1'b0;
    repeat (16) @(posedge sys_clk);
    n = 0;
    repeat (1024) begin
      @(posedge sys_clk);
      n += int'(countEn[0] === 1'b1);
    end
    chkCount(n, 0);
    wrapUp();
  end
endmodule
`default_nettype wire
